/* verilog/ofs_consts.vh */
// constants for the oscillator frequency select control block
// Functional notes
// - divider select register is 8 bits, code in bits 2:0, upper five read zero.
// - reset loads divider code from option byte frequency code bits 2:0.
// - two upper option frequency bits fix the band that decodes the code.
// - codes 0-3 give 24..3 or 32..4 MHz; 4,5 give 2,1 high band only.
// - double band bit runs raw oscillator at twice rate, cpu gets half; code 0 keeps raw at one tick, same as cpu.
// - after a write, up to three old clocks, then up to three held new clocks.
// - trim register holds a 6-bit speed field, bits 7:6 read zero.
// - trim register resets to the factory calibrated input value.
// - clock mode bits 7:6 pick main oscillator crystal, external clock or port.
// - clock mode bits 5:4 pick sub oscillator crystal, external clock or port.
// - sub drive mode bits value 1,0 selects ultra low power oscillation.
// - run status bit 0 controls whether the fast oscillator runs.
// - fast oscillator starts by itself when reset is released.
// - slow oscillator clocks only watchdog, rtc, interval timer and timer, never cpu.
// - slow oscillator runs when watchdog option or timer source bit is set.
// - slow oscillator stops only with watchdog on, source 0, standby-run 0, in standby.
// - five option bits choose reset frequency among twelve; other codes prohibited.
`ifndef OFS_CONSTS_VH
`define OFS_CONSTS_VH
`define OFS_ADDR_TRIM 20'hF00A0
`define OFS_ADDR_DIV 20'hF00A8
`define OFS_ADDR_CMC 20'hF00A1
`define OFS_ADDR_CSC 20'hF00A2
`define OFS_ADDR_SUPPLY 20'hF00F3
`define OFS_CMC_RESET 8'h00
`define OFS_CSC_RESET 8'hC0
`define OFS_SUPPLY_RESET 8'h00
`define OFS_CSC_FAST_HALT_BIT 0
`define OFS_SUPPLY_SRC_BIT 4
`define OFS_OLD_CLOCKS 2'd3
`define OFS_NEW_CLOCKS 2'd3
`define OFS_BOOT_WAIT 2'd3
`define OFS_MODE_PORT 2'b00
`define OFS_MODE_XTAL 2'b01
`define OFS_MODE_EXT 2'b11
`define OFS_DRIVE_ULP 2'b10
`endif

/* verilog/ofs_clk_div.v */
// programmable divider that turns the raw fast clock into enable pulses
`timescale 1ns/10ps
`default_nettype none
module ofs_clk_div (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [6:0] ratio,
  output reg tick
);
  reg [6:0] count;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count + 7'h01 >= ratio) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // ofs_clk_div
`default_nettype wire

/* verilog/ofs_ctrl.v */
// fast and slow on-chip oscillator control with registers and timed rate switch
`timescale 1ns/10ps
`default_nettype none
`include "ofs_consts.vh"
module ofs_ctrl (
  input wire clk,
  input wire rst_n,
  input wire [19:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [4:0] opt_freq_sel,
  input wire [1:0] opt_flash_mode,
  input wire watchdog_option_enable,
  input wire watchdog_standby_run,
  input wire [5:0] factory_trim,
  input wire standby_mode,
  output reg [5:0] trim_value,
  output reg fast_osc_run,
  output reg fast_clk_en,
  output reg cpu_clk_en,
  output reg [6:0] raw_ratio,
  output reg code_prohibited,
  output reg switch_busy,
  output reg [1:0] main_osc_mode,
  output reg [1:0] sub_osc_mode,
  output reg sub_ultra_low_power,
  output reg slow_osc_run,
  output reg slow_clk_to_timers
);
  localparam ST_IDLE = 2'd0;
  localparam ST_OLD = 2'd1;
  localparam ST_WAIT = 2'd2;

  // cycles of the 32 MHz base per output period, mapped to 40 MHz ticks
  function [6:0] period_of;
    input [1:0] band;
    input [2:0] code;
    begin
      case (code)
        3'd0: period_of = 7'd1;
        3'd1: period_of = 7'd2;
        3'd2: period_of = 7'd4;
        3'd3: period_of = 7'd8;
        3'd4: period_of = 7'd16;
        3'd5: period_of = 7'd32;
        default: period_of = 7'd32;
      endcase
    end
  endfunction

  function code_bad;
    input upper;
    input [2:0] code;
    begin
      code_bad = (code > 3'd5) || (!upper && code > 3'd3);
    end
  endfunction

  // raw period halves in the double band, but never below one tick
  function [6:0] half_of;
    input [6:0] period;
    begin
      half_of = (period[6:1] == 6'h00) ? 7'h01 : {1'b0, period[6:1]};
    end
  endfunction

  // option byte is a level from outside the clock domain
  reg [4:0] opt_s1, opt_s2, opt_s3;
  reg [4:0] opt_q;
  reg wdt_s1, wdt_s2, wdt_s3, wdt_q;
  reg sby_s1, sby_s2, sby_s3, sby_q;
  reg stb_s1, stb_s2, stb_s3, stb_q;
  reg [5:0] trm_s1, trm_s2, trm_s3;
  reg [1:0] fls_s1, fls_s2, fls_s3, fls_q;
  reg [1:0] boot_wait;
  reg boot_done;
  reg [2:0] div_code;
  reg [2:0] active_code;
  reg [2:0] pend_code;
  reg [7:0] clock_mode_register;
  reg [7:0] clock_run_status_register;
  reg [7:0] supply_mode;
  reg [1:0] state;
  reg [1:0] cnt;
  reg [2:0] next_active;
  wire div_tick;
  wire band_upper = opt_q[3];
  wire band_double = opt_q[4];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_s1 <= 5'h00;
      opt_s2 <= 5'h00;
      opt_s3 <= 5'h00;
      opt_q <= 5'h00;
      fls_s1 <= 2'b00;
      fls_s2 <= 2'b00;
      fls_s3 <= 2'b00;
      fls_q <= 2'b00;
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
      wdt_s3 <= 1'b0;
      wdt_q <= 1'b0;
      sby_s1 <= 1'b0;
      sby_s2 <= 1'b0;
      sby_s3 <= 1'b0;
      sby_q <= 1'b0;
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_s3 <= 1'b0;
      stb_q <= 1'b0;
      trm_s1 <= 6'h00;
      trm_s2 <= 6'h00;
      trm_s3 <= 6'h00;
      boot_wait <= 2'd0;
    end else begin
      opt_s1 <= opt_freq_sel;
      opt_s2 <= opt_s1;
      opt_s3 <= opt_s2;
      if (opt_s2 == opt_s3) opt_q <= opt_s3;
      fls_s1 <= opt_flash_mode;
      fls_s2 <= fls_s1;
      fls_s3 <= fls_s2;
      if (fls_s2 == fls_s3) fls_q <= fls_s3;
      wdt_s1 <= watchdog_option_enable;
      wdt_s2 <= wdt_s1;
      wdt_s3 <= wdt_s2;
      if (wdt_s2 == wdt_s3) wdt_q <= wdt_s3;
      sby_s1 <= watchdog_standby_run;
      sby_s2 <= sby_s1;
      sby_s3 <= sby_s2;
      if (sby_s2 == sby_s3) sby_q <= sby_s3;
      stb_s1 <= standby_mode;
      stb_s2 <= stb_s1;
      stb_s3 <= stb_s2;
      if (stb_s2 == stb_s3) stb_q <= stb_s3;
      trm_s1 <= factory_trim;
      trm_s2 <= trm_s1;
      trm_s3 <= trm_s2;
      // boot load waits until the third stage holds the pin levels
      if (boot_wait != `OFS_BOOT_WAIT) boot_wait <= boot_wait + 2'd1;
    end
  end

  wire div_write = reg_wr && (reg_addr == `OFS_ADDR_DIV);
  wire boot_load = !boot_done && (boot_wait == `OFS_BOOT_WAIT) &&
    (trm_s2 == trm_s3) && (opt_s2 == opt_s3);

  // register file
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done <= 1'b0;
      div_code <= 3'h0;
      trim_value <= 6'h00;
      clock_mode_register <= `OFS_CMC_RESET;
      clock_run_status_register <= `OFS_CSC_RESET;
      supply_mode <= `OFS_SUPPLY_RESET;
    end else if (boot_load) begin
      boot_done <= 1'b1;
      div_code <= opt_s3[2:0];
      trim_value <= trm_s3;
    end else if (boot_done && reg_wr) begin
      case (reg_addr)
        `OFS_ADDR_DIV: div_code <= reg_wdata[2:0];
        `OFS_ADDR_TRIM: trim_value <= reg_wdata[5:0];
        `OFS_ADDR_CMC: clock_mode_register <= reg_wdata;
        `OFS_ADDR_CSC: clock_run_status_register <= reg_wdata;
        `OFS_ADDR_SUPPLY: supply_mode <= reg_wdata & 8'h90;
        default: clock_mode_register <= clock_mode_register;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_ADDR_DIV: reg_rdata <= {5'h00, div_code};
        `OFS_ADDR_TRIM: reg_rdata <= {2'b00, trim_value};
        `OFS_ADDR_CMC: reg_rdata <= clock_mode_register;
        `OFS_ADDR_CSC: reg_rdata <= clock_run_status_register;
        `OFS_ADDR_SUPPLY: reg_rdata <= supply_mode;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // switch sequence on the divided clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 2'd0;
      active_code <= 3'h0;
      pend_code <= 3'h0;
    end else if (boot_load) begin
      active_code <= opt_s3[2:0];
    end else begin
      case (state)
        ST_IDLE: begin
          if (boot_done && div_write) begin
            pend_code <= reg_wdata[2:0];
            cnt <= 2'd0;
            state <= ST_OLD;
          end
        end
        ST_OLD: begin
          // switch only at a whole-period boundary
          if (div_tick) begin
            if (cnt == `OFS_OLD_CLOCKS - 2'd1) begin
              active_code <= pend_code;
              cnt <= 2'd0;
              state <= ST_WAIT;
            end else begin
              cnt <= cnt + 2'd1;
            end
          end
        end
        ST_WAIT: begin
          if (div_tick) begin
            if (cnt == `OFS_NEW_CLOCKS - 2'd1) begin
              // a code written mid-switch before this last new tick's cycle starts a fresh switch
              pend_code <= div_code;
              cnt <= 2'd0;
              state <= (div_code != active_code) ? ST_OLD : ST_IDLE;
            end else begin
              cnt <= cnt + 2'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    next_active = active_code;
  end

  wire fast_run_w = boot_done && !clock_run_status_register[`OFS_CSC_FAST_HALT_BIT];

  ofs_clk_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(fast_run_w),
    .ratio(period_of({band_double, band_upper}, next_active)),
    .tick(div_tick)
  );

  wire slow_on = wdt_q || supply_mode[`OFS_SUPPLY_SRC_BIT];
  wire slow_stop = wdt_q && !supply_mode[`OFS_SUPPLY_SRC_BIT] && !sby_q && stb_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_osc_run <= 1'b0;
      fast_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      raw_ratio <= 7'h01;
      code_prohibited <= 1'b0;
      switch_busy <= 1'b0;
      main_osc_mode <= `OFS_MODE_PORT;
      sub_osc_mode <= `OFS_MODE_PORT;
      sub_ultra_low_power <= 1'b0;
      slow_osc_run <= 1'b0;
      slow_clk_to_timers <= 1'b0;
    end else begin
      fast_osc_run <= fast_run_w;
      fast_clk_en <= div_tick;
      cpu_clk_en <= div_tick && (state != ST_WAIT);
      // raw at twice rate in double band except at code 0
      raw_ratio <= band_double ? half_of(period_of(2'b00, active_code)) :
        period_of(2'b00, active_code);
      code_prohibited <= code_bad(band_upper, div_code) ||
        (band_double ? (opt_q[2:0] != 3'h0) : code_bad(band_upper, opt_q[2:0])) ||
        (fls_q == 2'b01);
      switch_busy <= (state != ST_IDLE);
      main_osc_mode <= clock_mode_register[7:6];
      sub_osc_mode <= clock_mode_register[5:4];
      sub_ultra_low_power <= (clock_mode_register[2:1] == `OFS_DRIVE_ULP);
      slow_osc_run <= slow_on && !slow_stop;
      slow_clk_to_timers <= slow_on && !slow_stop;
    end
  end
endmodule // ofs_ctrl
`default_nettype wire

/* testbench/ofs_ctrl_assertions.sv */
// concurrent checks on the oscillator control ports
`timescale 1ns/10ps
`default_nettype none
module ofs_ctrl_chk (
  input wire clk,
  input wire rst_n,
  input wire [19:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [5:0] factory_trim,
  input wire watchdog_option_enable,
  input wire watchdog_standby_run,
  input wire [5:0] trim_value,
  input wire fast_osc_run,
  input wire fast_clk_en,
  input wire cpu_clk_en,
  input wire switch_busy,
  input wire slow_osc_run,
  input wire slow_clk_to_timers
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_div_read;
    reg_rd && reg_addr == 20'hF00A8 |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider upper bits set");
  property p_trim_read;
    reg_rd && reg_addr == 20'hF00A0 |=> reg_rdata == {2'b00, trim_value};
  endproperty
  a_trim_read: assert property (p_trim_read) else $error("trim read wrong");
  property p_cpu_fast;
    cpu_clk_en |-> fast_clk_en;
  endproperty
  a_cpu_fast: assert property (p_cpu_fast) else $error("cpu tick without fast tick");
  property p_switch_end;
    $rose(switch_busy) |-> ##[1:400] !switch_busy;
  endproperty
  a_switch_end: assert property (p_switch_end) else $error("switch never ends");
  property p_halt;
    !fast_osc_run && !$past(fast_osc_run, 2) |-> !fast_clk_en;
  endproperty
  a_halt: assert property (p_halt) else $error("tick while halted");
  property p_boot_trim;
    $rose(rst_n) |-> ##5 trim_value == factory_trim;
  endproperty
  a_boot_trim: assert property (p_boot_trim) else $error("trim not calibrated");
  property p_auto_start;
    $rose(rst_n) |-> ##5 fast_osc_run;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("fast osc not started");
  property p_slow_wdt;
    (watchdog_option_enable && watchdog_standby_run) [*6] |-> slow_osc_run;
  endproperty
  a_slow_wdt: assert property (p_slow_wdt) else $error("slow osc stopped");
  property p_slow_route;
    slow_clk_to_timers |-> slow_osc_run;
  endproperty
  a_slow_route: assert property (p_slow_route) else $error("slow clock without osc");
  c_switch: cover property ($fell(switch_busy));
  c_restart: cover property (!fast_osc_run ##1 fast_osc_run);
  c_slow_stop: cover property ($fell(slow_osc_run));
endmodule // ofs_ctrl_chk
bind ofs_ctrl ofs_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .factory_trim(factory_trim),
  .watchdog_option_enable(watchdog_option_enable), .watchdog_standby_run(watchdog_standby_run),
  .trim_value(trim_value), .fast_osc_run(fast_osc_run), .fast_clk_en(fast_clk_en),
  .cpu_clk_en(cpu_clk_en), .switch_busy(switch_busy), .slow_osc_run(slow_osc_run),
  .slow_clk_to_timers(slow_clk_to_timers));
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, wdt_en = 0, wdt_sb = 0, stby = 0;
  logic [19:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [4:0] opt = 5'h08;
  logic [1:0] flash = 2'h3; // full range mode adds no prohibition; codes 6 and 7 stay illegal
  logic [5:0] ftrim = 6'h2A;
  wire [7:0] rdata;
  wire [5:0] trim;
  wire [1:0] mmode, smode;
  wire [6:0] raw;
  wire fast_run, fast_en, cpu_en, prohib, busy, ulp, slow_run, slow_tm;
  int mismatches = 0, cmp_count = 0;
  ofs_ctrl u_ofs_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata), .opt_freq_sel(opt),
    .opt_flash_mode(flash), .watchdog_option_enable(wdt_en), .watchdog_standby_run(wdt_sb),
    .factory_trim(ftrim), .standby_mode(stby), .trim_value(trim), .fast_osc_run(fast_run),
    .fast_clk_en(fast_en), .cpu_clk_en(cpu_en), .raw_ratio(raw), .code_prohibited(prohib),
    .switch_busy(busy), .main_osc_mode(mmode), .sub_osc_mode(smode),
    .sub_ultra_low_power(ulp), .slow_osc_run(slow_run), .slow_clk_to_timers(slow_tm));
  always #12.5 clk = ~clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [19:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic idle;
    int i;
    settle(3);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    #1 chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic measure_period(output int n);
    n = 0;
    @(posedge clk iff fast_en === 1'b1);
    do begin @(posedge clk); n++; end while (fast_en !== 1'b1 && n < 99);
  endtask
  task automatic do_reset(input logic [4:0] o);
    @(posedge clk);
    rst_n <= 1'b0;
    opt <= o;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle(6);
  endtask
  task automatic t_codes;
    int c, n;
    for (c = 0; c < 8; c++) begin
      wr(20'hF00A8, {5'h1F, c[2:0]});
      idle();
      rchk(20'hF00A8, {5'h00, c[2:0]}, "div");
      chk("prohib", {7'h00, c > 5}, {7'h00, prohib});
      if (c < 6) begin
        chk("raw", 8'(1 << c), {1'b0, raw});
        measure_period(n);
        chk("period", 8'(1 << c), 8'(n));
      end
    end
    wr(20'hF00A8, 8'h00);
    idle();
  endtask
  task automatic t_switch;
    int i, n;
    n = 0;
    wr(20'hF00A8, 8'h02); // written while the fast clock runs the cpu
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (fast_en === 1'b1 && cpu_en !== 1'b1) n++;
    end
    chk("held", 8'd3, 8'(n));
  endtask
  task automatic t_halt;
    wr(20'hF00A2, 8'hC1);
    settle(3);
    chk("halt", 8'h00, {7'h00, fast_run});
    wr(20'hF00A2, 8'hC0);
    settle(3);
    chk("run", 8'h01, {7'h00, fast_run});
  endtask
  task automatic t_cmc;
    wr(20'hF00A1, 8'h74);
    settle(2);
    chk("cmc", 8'h0F, {3'h0, mmode, smode, ulp});
    wr(20'hF00A1, 8'hF0);
    settle(2);
    chk("cmc", 8'h1E, {3'h0, mmode, smode, ulp});
  endtask
  task automatic t_slow;
    wr(20'hF00F3, 8'h10);
    settle(8);
    chk("slow", 8'h01, {7'h00, slow_run});
    chk("slow_tm", 8'h01, {7'h00, slow_tm});
    wr(20'hF00F3, 8'h00);
    wdt_en <= 1'b1;
    stby <= 1'b1;
    settle(8);
    chk("slow", 8'h00, {7'h00, slow_run});
    chk("slow_tm", 8'h00, {7'h00, slow_tm});
    @(posedge clk);
    stby <= 1'b0;
    wdt_sb <= 1'b1;
    settle(8);
    chk("slow", 8'h01, {7'h00, slow_run});
    chk("slow_tm", 8'h01, {7'h00, slow_tm});
  endtask
  task automatic t_band;
    int n;
    do_reset(5'h03);
    rchk(20'hF00A8, 8'h03, "div");
    wr(20'hF00A8, 8'h04);
    idle();
    chk("prohib", 8'h01, {7'h00, prohib});
    do_reset(5'h10);
    rchk(20'hF00A8, 8'h00, "div");
    chk("prohib", 8'h00, {7'h00, prohib});
    wr(20'hF00A8, 8'h01);
    idle();
    chk("raw", 8'h01, {1'b0, raw});
    measure_period(n);
    chk("period", 8'h02, 8'(n));
    do_reset(5'h19);
    chk("prohib", 8'h01, {7'h00, prohib});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle(6);
    rchk(20'hF00A8, 8'h00, "div");
    rchk(20'hF00A0, 8'h2A, "trim");
    rchk(20'hF0000, 8'h00, "unmapped");
    t_codes();
    t_switch();
    t_halt();
    t_cmc();
    t_slow();
    t_band();
    report_and_stop();
  end
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
